// File: include/dtbe_defines.svh
// Constants for the data transfer and bit execution core
// Functional notes
// - Branch when interrupts enabled, 1/2 cycles
// - Branch when interrupts disabled, 1/2 cycles
// - Indirect load then pointer increment, 2 cycles
// - Pointer decrement then indirect load, 2 cycles
// - Y/Z plus offset load, pointer kept
// - Indirect store then pointer increment, 2 cycles
// - Pointer decrement then indirect store, 2 cycles
// - Y/Z plus offset store, pointer kept
// - Direct address load, 2 cycles, no flags
// - Direct address store, 2 cycles, no flags
// - Program memory byte read via Z, 3 cycles
// - Push register to stack, 2 cycles
// - Pop register from stack, 2 cycles
// - Force one I/O bit high, 2 cycles
// - Force one I/O bit low, 2 cycles
// - Rotate up through carry, update Z C N V
// - Rotate down through carry, update Z C N V
// - Copy register bit into T flag
// - Copy T flag into register bit
// - Force overflow flag high
// - Force overflow flag low
// - Force signed flag high or low
`ifndef DTBE_DEFINES_SVH
`define DTBE_DEFINES_SVH
// ****************************************
// Flag register bit positions
// ****************************************
`define DTBE_FLAG_C 0
`define DTBE_FLAG_Z 1
`define DTBE_FLAG_N 2
`define DTBE_FLAG_V 3
`define DTBE_FLAG_S 4
`define DTBE_FLAG_H 5
`define DTBE_FLAG_T 6
`define DTBE_FLAG_I 7
// ****************************************
// Reset values and register indices
// ****************************************
`define DTBE_SP_RESET 16'h00FF
`define DTBE_PC_RESET 16'h0000
`define DTBE_FLAGS_RESET 8'h00
`define DTBE_PTR_BASE 5'h1A
`endif

// File: include/dtbe_pkg.sv
// Types shared by the data transfer and bit execution core
package dtbe_pkg;
	typedef enum logic [4:0] {
		OP_NOP, OP_BRANCH_IRQ_EN, OP_BRANCH_IRQ_DIS, OP_LOAD_INDIRECT,
		OP_WRITE_INDIRECT, OP_LOAD_DIRECT, OP_WRITE_DIRECT, OP_PROG_READ,
		OP_PUSH, OP_POP, OP_IO_FORCE_ONE, OP_IO_FORCE_ZERO, OP_ROTATE_UP,
		OP_ROTATE_DOWN, OP_BIT_TO_FLAG, OP_FLAG_TO_BIT, OP_OVF_FORCE_ONE,
		OP_OVF_FORCE_ZERO, OP_SIGN_FORCE_ONE, OP_SIGN_FORCE_ZERO,
		OP_FLAG_FORCE_ONE, OP_FLAG_FORCE_ZERO
	} dtbe_op_type;
	typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z, PTR_NONE} dtbe_ptr_type;
	typedef enum logic [1:0] {AM_PLAIN, AM_POSTINC, AM_PREDEC, AM_OFFSET} dtbe_amode_type;
	typedef struct packed {
		dtbe_op_type op;
		logic [4:0] rd;
		logic [4:0] rr;
		dtbe_ptr_type ptr;
		dtbe_amode_type amode;
		logic [5:0] q;
		logic [15:0] k;
		logic [2:0] b;
	} dtbe_inst_type;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic re;
		logic we;
	} dtbe_dmem_type;
	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic re;
		logic we;
	} dtbe_io_type;
	typedef struct packed {
		logic [15:0] addr;
		logic re;
	} dtbe_pmem_type;
	typedef enum logic [5:0] {
		S_IDLE = 6'h01, S_DATA = 6'h02, S_PWAIT = 6'h04,
		S_PDATA = 6'h08, S_IORD = 6'h10, S_BUBBLE = 6'h20
	} dtbe_state_type;
endpackage : dtbe_pkg

// File: rtl/dtbe_core.sv
// Execution core for branches by the I flag, data transfers and bit operations
`timescale 1ns/100ps
`include "dtbe_defines.svh"
module dtbe_core #(
	parameter logic [15:0] SP_INIT = `DTBE_SP_RESET
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic instValid,
	input wire dtbe_pkg::dtbe_inst_type instIn,
	output logic instReady_q,
	output dtbe_pkg::dtbe_dmem_type dmemReq_q,
	input wire logic [7:0] dmemRdata,
	output dtbe_pkg::dtbe_io_type ioReq_q,
	input wire logic [7:0] ioRdata,
	output dtbe_pkg::dtbe_pmem_type pmemReq_q,
	input wire logic [7:0] pmemRdata,
	output logic [15:0] pc_q,
	output logic [15:0] sp_q,
	output logic [7:0] flags_q,
	input wire logic [4:0] dbgSel,
	output logic [7:0] dbgData_q
);
	import dtbe_pkg::*;

	// ****************************************
	// State
	// ****************************************
	logic [7:0] regs_q [32];
	logic [7:0] regs_d [32];
	dtbe_state_type state_q, state_d;
	logic instReady_d;
	dtbe_dmem_type dmemReq_d;
	dtbe_io_type ioReq_d;
	dtbe_pmem_type pmemReq_d;
	logic [15:0] pc_d, sp_d;
	logic [7:0] flags_d, dbgData_d;
	logic [4:0] dst_q, dst_d;
	logic [2:0] ioBit_q, ioBit_d;
	logic ioSet_q, ioSet_d;

	// ****************************************
	// Operand decode
	// ****************************************
	logic accept;
	logic [4:0] ptrIdx;
	logic [15:0] ptrVal, effAddr, ptrNew, brOff, brTarget;
	logic [7:0] srcVal, dstVal, rotRes;
	logic ptrWrite;

	// Instruction taken only while no earlier access is pending
	assign accept = instValid && instReady_q;
	// Pointer pairs sit at R26/R27, R28/R29, R30/R31
	assign ptrIdx = `DTBE_PTR_BASE + {2'h0, instIn.ptr, 1'b0};
	assign ptrVal = {regs_q[ptrIdx + 5'h01], regs_q[ptrIdx]};
	assign srcVal = regs_q[instIn.rr];
	assign dstVal = regs_q[instIn.rd];
	assign brOff = {{9{instIn.k[6]}}, instIn.k[6:0]};
	assign brTarget = pc_q + brOff + 16'h0001;

	// Address and updated pointer, full 16-bit carry or borrow
	always_comb begin
		effAddr = ptrVal;
		ptrNew = ptrVal;
		ptrWrite = 1'b0;
		case (instIn.amode)
			AM_POSTINC: begin
				ptrNew = ptrVal + 16'h0001;
				ptrWrite = 1'b1;
			end
			AM_PREDEC: begin
				effAddr = ptrVal - 16'h0001;
				ptrNew = effAddr;
				ptrWrite = 1'b1;
			end
			AM_OFFSET: begin
				effAddr = ptrVal + {10'h000, instIn.q};
			end
			default: begin
				effAddr = ptrVal;
			end
		endcase
	end

	// Rotate result; carry goes in at the vacated end
	always_comb begin
		if (instIn.op == OP_ROTATE_UP) begin
			rotRes = {dstVal[6:0], flags_q[`DTBE_FLAG_C]};
		end else begin
			rotRes = {flags_q[`DTBE_FLAG_C], dstVal[7:1]};
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		regs_d = regs_q;
		state_d = state_q;
		instReady_d = instReady_q;
		dmemReq_d = dmemReq_q;
		dmemReq_d.re = 1'b0;
		dmemReq_d.we = 1'b0;
		ioReq_d = ioReq_q;
		ioReq_d.re = 1'b0;
		ioReq_d.we = 1'b0;
		pmemReq_d = pmemReq_q;
		pmemReq_d.re = 1'b0;
		pc_d = pc_q;
		sp_d = sp_q;
		flags_d = flags_q;
		dst_d = dst_q;
		ioBit_d = ioBit_q;
		ioSet_d = ioSet_q;
		dbgData_d = regs_q[dbgSel];
		case (state_q)
			S_IDLE: begin
				if (accept) begin
					pc_d = pc_q + 16'h0001;
					dst_d = instIn.rd;
					case (instIn.op)
						OP_BRANCH_IRQ_EN, OP_BRANCH_IRQ_DIS: begin
							// Taken branch costs one bubble cycle
							if (flags_q[`DTBE_FLAG_I] == (instIn.op == OP_BRANCH_IRQ_EN)) begin
								pc_d = brTarget;
								instReady_d = 1'b0;
								state_d = S_BUBBLE;
							end
						end
						OP_LOAD_INDIRECT: begin
							dmemReq_d.addr = effAddr;
							dmemReq_d.re = 1'b1;
							if (ptrWrite) begin
								regs_d[ptrIdx] = ptrNew[7:0];
								regs_d[ptrIdx + 5'h01] = ptrNew[15:8];
							end
							instReady_d = 1'b0;
							state_d = S_DATA;
						end
						OP_WRITE_INDIRECT: begin
							dmemReq_d.addr = effAddr;
							dmemReq_d.wdata = srcVal;
							dmemReq_d.we = 1'b1;
							if (ptrWrite) begin
								regs_d[ptrIdx] = ptrNew[7:0];
								regs_d[ptrIdx + 5'h01] = ptrNew[15:8];
							end
							instReady_d = 1'b0;
							state_d = S_BUBBLE;
						end
						OP_LOAD_DIRECT: begin
							// Two-word instruction
							pc_d = pc_q + 16'h0002;
							dmemReq_d.addr = instIn.k;
							dmemReq_d.re = 1'b1;
							instReady_d = 1'b0;
							state_d = S_DATA;
						end
						OP_WRITE_DIRECT: begin
							pc_d = pc_q + 16'h0002;
							dmemReq_d.addr = instIn.k;
							dmemReq_d.wdata = srcVal;
							dmemReq_d.we = 1'b1;
							instReady_d = 1'b0;
							state_d = S_BUBBLE;
						end
						OP_PROG_READ: begin
							// Decoder gives rd = 0 for the short form
							pmemReq_d.addr = ptrVal;
							pmemReq_d.re = 1'b1;
							if (instIn.amode == AM_POSTINC) begin
								regs_d[ptrIdx] = ptrNew[7:0];
								regs_d[ptrIdx + 5'h01] = ptrNew[15:8];
							end
							instReady_d = 1'b0;
							state_d = S_PWAIT;
						end
						OP_PUSH: begin
							// Stack grows down: write then decrement
							dmemReq_d.addr = sp_q;
							dmemReq_d.wdata = srcVal;
							dmemReq_d.we = 1'b1;
							sp_d = sp_q - 16'h0001;
							instReady_d = 1'b0;
							state_d = S_BUBBLE;
						end
						OP_POP: begin
							dmemReq_d.addr = sp_q + 16'h0001;
							dmemReq_d.re = 1'b1;
							sp_d = sp_q + 16'h0001;
							instReady_d = 1'b0;
							state_d = S_DATA;
						end
						OP_IO_FORCE_ONE, OP_IO_FORCE_ZERO: begin
							// Read-modify-write keeps the other bits
							ioReq_d.addr = instIn.k[5:0];
							ioReq_d.re = 1'b1;
							ioBit_d = instIn.b;
							ioSet_d = (instIn.op == OP_IO_FORCE_ONE);
							instReady_d = 1'b0;
							state_d = S_IORD;
						end
						OP_ROTATE_UP, OP_ROTATE_DOWN: begin
							regs_d[instIn.rd] = rotRes;
							flags_d[`DTBE_FLAG_C] = (instIn.op == OP_ROTATE_UP) ?
								dstVal[7] : dstVal[0];
							flags_d[`DTBE_FLAG_Z] = (rotRes == 8'h00);
							flags_d[`DTBE_FLAG_N] = rotRes[7];
							flags_d[`DTBE_FLAG_V] = rotRes[7] ^ flags_d[`DTBE_FLAG_C];
						end
						OP_BIT_TO_FLAG: begin
							flags_d[`DTBE_FLAG_T] = srcVal[instIn.b];
						end
						OP_FLAG_TO_BIT: begin
							regs_d[instIn.rd][instIn.b] = flags_q[`DTBE_FLAG_T];
						end
						OP_OVF_FORCE_ONE: begin
							flags_d[`DTBE_FLAG_V] = 1'b1;
						end
						OP_OVF_FORCE_ZERO: begin
							flags_d[`DTBE_FLAG_V] = 1'b0;
						end
						OP_SIGN_FORCE_ONE: begin
							flags_d[`DTBE_FLAG_S] = 1'b1;
						end
						OP_SIGN_FORCE_ZERO: begin
							flags_d[`DTBE_FLAG_S] = 1'b0;
						end
						OP_FLAG_FORCE_ONE: begin
							flags_d[instIn.b] = 1'b1;
						end
						OP_FLAG_FORCE_ZERO: begin
							flags_d[instIn.b] = 1'b0;
						end
						default: begin
							pc_d = pc_q + 16'h0001;
						end
					endcase
				end
			end
			S_DATA: begin
				// Read data is valid while the read strobe stands
				regs_d[dst_q] = dmemRdata;
				instReady_d = 1'b1;
				state_d = S_IDLE;
			end
			S_PWAIT: begin
				// Program memory answers a cycle after its request
				state_d = S_PDATA;
			end
			S_PDATA: begin
				regs_d[dst_q] = pmemRdata;
				instReady_d = 1'b1;
				state_d = S_IDLE;
			end
			S_IORD: begin
				ioReq_d.wdata = ioRdata;
				ioReq_d.wdata[ioBit_q] = ioSet_q;
				ioReq_d.we = 1'b1;
				instReady_d = 1'b1;
				state_d = S_IDLE;
			end
			S_BUBBLE: begin
				instReady_d = 1'b1;
				state_d = S_IDLE;
			end
			default: begin
				instReady_d = 1'b1;
				state_d = S_IDLE;
			end
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			regs_q <= '{default: 8'h00};
			state_q <= S_IDLE;
			instReady_q <= 1'b1;
			dmemReq_q <= '0;
			ioReq_q <= '0;
			pmemReq_q <= '0;
			pc_q <= `DTBE_PC_RESET;
			sp_q <= SP_INIT;
			flags_q <= `DTBE_FLAGS_RESET;
			dst_q <= 5'h00;
			ioBit_q <= 3'h0;
			ioSet_q <= 1'b0;
			dbgData_q <= 8'h00;
		end else begin
			regs_q <= regs_d;
			state_q <= state_d;
			instReady_q <= instReady_d;
			dmemReq_q <= dmemReq_d;
			ioReq_q <= ioReq_d;
			pmemReq_q <= pmemReq_d;
			pc_q <= pc_d;
			sp_q <= sp_d;
			flags_q <= flags_d;
			dst_q <= dst_d;
			ioBit_q <= ioBit_d;
			ioSet_q <= ioSet_d;
			dbgData_q <= dbgData_d;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	AST_BR_EN_TAKEN: assert property (
		accept && instIn.op == OP_BRANCH_IRQ_EN && flags_q[`DTBE_FLAG_I]
		|=> pc_q == $past(brTarget) && !instReady_q ##1 instReady_q
	) else $error("taken branch target or timing wrong");

	AST_BR_DIS_SKIP: assert property (
		accept && instIn.op == OP_BRANCH_IRQ_DIS && flags_q[`DTBE_FLAG_I]
		|=> instReady_q && pc_q == $past(pc_q) + 16'h0001 && $stable(flags_q)
	) else $error("untaken branch misbehaved");

	AST_LOAD_TWO: assert property (
		accept && instIn.op == OP_LOAD_INDIRECT
		|=> !instReady_q && $stable(flags_q) ##1 instReady_q
		&& regs_q[$past(dst_q)] == $past(dmemRdata)
	) else $error("indirect load result or timing wrong");

	AST_PREDEC_ADDR: assert property (
		accept && instIn.amode == AM_PREDEC
		&& (instIn.op == OP_LOAD_INDIRECT || instIn.op == OP_WRITE_INDIRECT)
		|=> dmemReq_q.addr == $past(ptrVal) - 16'h0001
	) else $error("pre-decrement address wrong");

	AST_OFFSET_ADDR: assert property (
		accept && instIn.amode == AM_OFFSET && instIn.op == OP_LOAD_INDIRECT
		|=> dmemReq_q.re && dmemReq_q.addr == $past(ptrVal) + {10'h000, $past(instIn.q)}
	) else $error("offset address wrong");

	AST_STORE_WR: assert property (
		accept && instIn.op == OP_WRITE_INDIRECT
		|=> dmemReq_q.we && dmemReq_q.wdata == $past(srcVal) ##1 !dmemReq_q.we
	) else $error("store write strobe wrong");

	AST_PROG_THREE: assert property (
		accept && instIn.op == OP_PROG_READ
		|=> !instReady_q [*2] ##1 instReady_q
	) else $error("program memory read not three cycles");

	AST_IO_FORCE: assert property (
		accept && instIn.op == OP_IO_FORCE_ONE
		|=> ioReq_q.re ##1 ioReq_q.we && ioReq_q.wdata[$past(instIn.b, 2)]
	) else $error("I/O bit not forced high");

	AST_ROT_CARRY: assert property (
		accept && instIn.op == OP_ROTATE_UP
		|=> flags_q[`DTBE_FLAG_C] == $past(dstVal[7])
		&& regs_q[$past(instIn.rd)][0] == $past(flags_q[`DTBE_FLAG_C])
	) else $error("rotate up carry path wrong");

	AST_BIT_TO_T: assert property (
		accept && instIn.op == OP_BIT_TO_FLAG
		|=> flags_q[`DTBE_FLAG_T] == $past(srcVal[instIn.b])
	) else $error("T flag copy wrong");

	AST_OVF_ONE: assert property (
		accept && instIn.op == OP_OVF_FORCE_ONE
		|=> flags_q == ($past(flags_q) | 8'h08)
	) else $error("overflow force disturbed flags");
endmodule : dtbe_core

// File: tb/dtbe_mem_model.sv
// Memory model facing the core: data, I/O and program space
`timescale 1ns/100ps
module dtbe_mem_model (
	input wire logic ref_clk,
	input wire dtbe_pkg::dtbe_dmem_type dmemReq,
	output logic [7:0] dmemRdata,
	input wire dtbe_pkg::dtbe_io_type ioReq,
	output logic [7:0] ioRdata,
	input wire dtbe_pkg::dtbe_pmem_type pmemReq,
	output logic [7:0] pmemRdata
);
	import dtbe_pkg::*;
	// ****************************************
	// Storage and read paths
	// ****************************************
	logic [7:0] dmem [0:65535];
	logic [7:0] io [0:63];
	logic [7:0] pmem [0:65535];
	logic [15:0] pAddr = 16'h0000;
	logic pVal = 1'b0;
	logic [7:0] junk = 8'h5A;
	// Idle read lines toggle so a stale byte never passes for data
	always_comb dmemRdata = dmemReq.re ? dmem[dmemReq.addr] : junk;
	always_comb ioRdata = ioReq.re ? io[ioReq.addr] : ~junk;
	always_comb pmemRdata = pVal ? pmem[pAddr] : junk;
	// Writes land at the edge; program bytes come a cycle after the strobe
	always_ff @(posedge ref_clk) begin
		junk <= ~junk;
		pVal <= pmemReq.re;
		pAddr <= pmemReq.addr;
	end
	// Plain always: the bench also seeds these arrays directly between accesses
	always @(posedge ref_clk) begin
		if (dmemReq.we) dmem[dmemReq.addr] <= dmemReq.wdata;
		if (ioReq.we) io[ioReq.addr] <= ioReq.wdata;
	end
endmodule : dtbe_mem_model

// File: tb/tb_data_transfer_bit_exec.sv
// Self-checking bench for the data transfer and bit execution core
`timescale 1ns/100ps
module tb_data_transfer_bit_exec;
	import dtbe_pkg::*;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic ref_clk = 1'b0;
	logic sysRst = 1'b1;
	logic instValid = 1'b0;
	dtbe_inst_type instIn = '0;
	logic [4:0] dbgSel = 5'h00;
	logic instReady;
	dtbe_dmem_type dmemReq;
	dtbe_io_type ioReq;
	dtbe_pmem_type pmemReq;
	logic [7:0] dmemRdata, ioRdata, pmemRdata, flags, dbgData;
	logic [15:0] pc, sp;
	logic [7:0] expFlags = 8'h00;
	logic [7:0] fm = 8'hFF;
	int errorCnt = 0;
	int nTests = 0;
	dtbe_core u_dtbe_core (.ref_clk(ref_clk), .sys_rst(sysRst), .instValid(instValid),
		.instIn(instIn), .instReady_q(instReady), .dmemReq_q(dmemReq), .dmemRdata(dmemRdata),
		.ioReq_q(ioReq), .ioRdata(ioRdata), .pmemReq_q(pmemReq), .pmemRdata(pmemRdata),
		.pc_q(pc), .sp_q(sp), .flags_q(flags), .dbgSel(dbgSel), .dbgData_q(dbgData));
	dtbe_mem_model u_dtbe_mem_model (.ref_clk(ref_clk), .dmemReq(dmemReq),
		.dmemRdata(dmemRdata), .ioReq(ioReq), .ioRdata(ioRdata), .pmemReq(pmemReq),
		.pmemRdata(pmemRdata));
	initial forever #50 ref_clk = ~ref_clk;
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		nTests++;
		if (g !== e) begin
			errorCnt++;
			$display("BAD %s exp %h got %h", name, e, g);
		end
	endtask : chk
	function automatic dtbe_inst_type mk(dtbe_op_type op, logic [4:0] r,
		dtbe_ptr_type p = PTR_NONE, dtbe_amode_type m = AM_PLAIN, logic [15:0] k = 16'h0000,
		logic [2:0] b = 3'h0, logic [5:0] q = 6'h00);
		mk = '{op: op, rd: r, rr: r, ptr: p, amode: m, q: q, k: k, b: b};
	endfunction : mk
	// Issue one instruction; judge busy length, pc step and the flag byte
	task automatic run(input dtbe_inst_type i, input int busy, input logic [15:0] step);
		logic [15:0] pc0;
		int n;
		pc0 = pc;
		n = 0;
		@(posedge ref_clk);
		instValid <= 1'b1;
		instIn <= i;
		@(posedge ref_clk);
		instValid <= 1'b0;
		do @(negedge ref_clk); while (instReady !== 1'b1 && ++n < 20);
		chk("busy", busy, n);
		chk("pc", pc0 + step, pc);
		chk("flags", expFlags & fm, flags & fm);
	endtask : run
	task automatic poke(input logic [15:0] a, input logic [7:0] v);
		u_dtbe_mem_model.dmem[a] = v;
	endtask : poke
	task automatic chkMem(input logic [15:0] a, input logic [7:0] e);
		chk("dmem", e, u_dtbe_mem_model.dmem[a]);
	endtask : chkMem
	// Registers are only reachable through loads, so seed a byte and fetch it
	task automatic setReg(input logic [4:0] r, input logic [7:0] v);
		poke(16'hF000 + r, v);
		run(mk(OP_LOAD_DIRECT, r, PTR_NONE, AM_PLAIN, 16'hF000 + r), 1, 2);
	endtask : setReg
	task automatic peek(input logic [4:0] r, input logic [7:0] e);
		@(posedge ref_clk);
		dbgSel <= r;
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk($sformatf("r%0d", r), e, dbgData);
	endtask : peek
	task automatic setPtr(input logic [4:0] r, input logic [15:0] v);
		setReg(r, v[7:0]);
		setReg(r + 5'h01, v[15:8]);
	endtask : setPtr
	task automatic peekPtr(input logic [4:0] r, input logic [15:0] v);
		peek(r, v[7:0]);
		peek(r + 5'h01, v[15:8]);
	endtask : peekPtr
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic testLoads;
		poke(16'h00FF, 8'h11);
		poke(16'h01FF, 8'h22);
		poke(16'h033F, 8'h33);
		setPtr(26, 16'h00FF);
		setPtr(28, 16'h0200);
		setPtr(30, 16'h0300);
		run(mk(OP_LOAD_INDIRECT, 2, PTR_X, AM_POSTINC), 1, 1);
		run(mk(OP_LOAD_INDIRECT, 3, PTR_Y, AM_PREDEC), 1, 1);
		run(mk(OP_LOAD_INDIRECT, 4, PTR_Z, AM_OFFSET, 0, 0, 6'h3F), 1, 1);
		peek(2, 8'h11);
		peek(3, 8'h22);
		peek(4, 8'h33);
		peekPtr(26, 16'h0100);
		peekPtr(28, 16'h01FF);
		peekPtr(30, 16'h0300);
	endtask : testLoads
	task automatic testStores;
		run(mk(OP_WRITE_INDIRECT, 2, PTR_X, AM_POSTINC), 1, 1);
		run(mk(OP_WRITE_INDIRECT, 3, PTR_Y, AM_PREDEC), 1, 1);
		run(mk(OP_WRITE_INDIRECT, 4, PTR_Z, AM_OFFSET, 0, 0, 6'h01), 1, 1);
		run(mk(OP_WRITE_DIRECT, 2, PTR_NONE, AM_PLAIN, 16'h0400), 1, 2);
		run(mk(OP_LOAD_INDIRECT, 5, PTR_Y, AM_PLAIN), 1, 1);
		run(mk(OP_WRITE_INDIRECT, 5, PTR_Z, AM_PLAIN), 1, 1);
		chkMem(16'h0300, 8'h22);
		peek(5, 8'h22);
		chkMem(16'h0100, 8'h11);
		chkMem(16'h01FE, 8'h22);
		chkMem(16'h0301, 8'h33);
		chkMem(16'h0400, 8'h11);
		peekPtr(26, 16'h0101);
		peekPtr(28, 16'h01FE);
		peekPtr(30, 16'h0300);
	endtask : testStores
	task automatic testProgStack;
		u_dtbe_mem_model.pmem[16'h0300] = 8'h77;
		u_dtbe_mem_model.pmem[16'h0301] = 8'h78;
		run(mk(OP_PROG_READ, 6, PTR_Z, AM_POSTINC), 2, 1);
		run(mk(OP_PROG_READ, 0, PTR_Z, AM_PLAIN), 2, 1);
		peek(6, 8'h77);
		peek(0, 8'h78);
		peekPtr(30, 16'h0301);
		run(mk(OP_PUSH, 6), 1, 1);
		chkMem(16'h00FF, 8'h77);
		chk("sp", 16'h00FE, sp);
		run(mk(OP_POP, 7), 1, 1);
		chk("sp", 16'h00FF, sp);
		peek(7, 8'h77);
	endtask : testProgStack
	task automatic testIo;
		u_dtbe_mem_model.io[5] = 8'hA0;
		run(mk(OP_IO_FORCE_ONE, 0, PTR_NONE, AM_PLAIN, 16'h0005, 3'h0), 1, 1);
		@(negedge ref_clk);
		chk("io", 8'hA1, u_dtbe_mem_model.io[5]);
		run(mk(OP_IO_FORCE_ZERO, 0, PTR_NONE, AM_PLAIN, 16'h0005, 3'h7), 1, 1);
		@(negedge ref_clk);
		chk("io", 8'h21, u_dtbe_mem_model.io[5]);
	endtask : testIo
	// Overflow is left unjudged after rotates, then forced to a known level
	task automatic testBits;
		setReg(8, 8'h80);
		expFlags[0] = 1'b1;
		run(mk(OP_FLAG_FORCE_ONE, 0), 0, 1);
		fm = 8'hF7;
		run(mk(OP_ROTATE_UP, 8), 0, 1);
		peek(8, 8'h01);
		expFlags[2:0] = 3'b101;
		run(mk(OP_ROTATE_DOWN, 8), 0, 1);
		peek(8, 8'h80);
		expFlags[2:0] = 3'b100;
		run(mk(OP_FLAG_FORCE_ZERO, 0), 0, 1);
		expFlags[2:0] = 3'b010;
		run(mk(OP_ROTATE_DOWN, 9), 0, 1);
		fm = 8'hFF;
		expFlags[3] = 1'b0;
		run(mk(OP_OVF_FORCE_ZERO, 0), 0, 1);
		expFlags[6] = 1'b1;
		run(mk(OP_BIT_TO_FLAG, 8, PTR_NONE, AM_PLAIN, 0, 3'h7), 0, 1);
		run(mk(OP_FLAG_TO_BIT, 9, PTR_NONE, AM_PLAIN, 0, 3'h3), 0, 1);
		peek(9, 8'h08);
		expFlags[3] = 1'b1;
		run(mk(OP_OVF_FORCE_ONE, 0), 0, 1);
		expFlags[3] = 1'b0;
		run(mk(OP_OVF_FORCE_ZERO, 0), 0, 1);
		expFlags[4] = 1'b1;
		run(mk(OP_SIGN_FORCE_ONE, 0), 0, 1);
		expFlags[4] = 1'b0;
		run(mk(OP_SIGN_FORCE_ZERO, 0), 0, 1);
	endtask : testBits
	task automatic testBranch;
		run(mk(OP_NOP, 0), 0, 1);
		run(mk(OP_BRANCH_IRQ_EN, 0, PTR_NONE, AM_PLAIN, 16'h0005), 0, 1);
		run(mk(OP_BRANCH_IRQ_DIS, 0, PTR_NONE, AM_PLAIN, 16'h007E), 1, 16'hFFFF);
		expFlags[7] = 1'b1;
		run(mk(OP_FLAG_FORCE_ONE, 0, PTR_NONE, AM_PLAIN, 0, 3'h7), 0, 1);
		run(mk(OP_BRANCH_IRQ_EN, 0, PTR_NONE, AM_PLAIN, 16'h0005), 1, 6);
		run(mk(OP_BRANCH_IRQ_DIS, 0, PTR_NONE, AM_PLAIN, 16'h0005), 0, 1);
	endtask : testBranch
	// ****************************************
	// Sequence, watchdog and verdict
	// ****************************************
	task automatic finishTest;
		if (errorCnt == 0 && nTests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finishTest
	initial begin
		repeat (20) @(posedge ref_clk);
		sysRst <= 1'b0;
		@(negedge ref_clk);
		chk("pc", 16'h0000, pc);
		chk("sp", 16'h00FF, sp);
		chk("flags", 8'h00, flags);
		testLoads();
		testStores();
		testProgStack();
		testIo();
		testBits();
		testBranch();
		finishTest();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		errorCnt++;
		finishTest();
	end
endmodule : tb_data_transfer_bit_exec
